/* File: switch_stacking_forwarder.sv */
// Purpose: forwarding decision for a switch that is one member of a stack
// Assumes: lookup results and flood masks are valid in the pkt_valid cycle
// Notes: answer comes two cycles after pkt_valid
// What this block does, and what software must do
// RQ1 - own and master numbers, up to sixteen
// RQ2 - sixteen slots, index above 55 maps nowhere
// RQ3 - 10G fiber links use compact framing
// RQ4 - other links keep normal framing
// RQ5 - remote traffic leaves only on masked slots
// RQ6 - eight link groups with slot member masks
// RQ7 - software puts at most eight links per group
// RQ8 - optionally drop packets we originated
// RQ9 - non-unicast never leaves on blocked slots
// RQ10 - first device forwards known unicast by lookup
// RQ11 - neighbour uses carried device and port
// RQ12 - lookup miss floods the unicast miss mask
// RQ13 - neighbour floods its own unicast miss mask
// RQ14 - multicast group index reused by neighbours
// RQ15 - multicast miss floods mask by family
// RQ16 - broadcast floods the broadcast mask
// RQ17 - unicast routing only in first device
// RQ18 - multicast routing in every device
// RQ19 - software adds links to unicast miss mask
// RQ20 - header carries source device and forwarding type
//
// Strobed register access and the address map were decided locally.
module switch_stacking_forwarder
    import stack_fwd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic pkt_valid,
    input wire logic pkt_from_link,
    input wire logic pkt_is_mc,
    input wire logic pkt_is_bc,
    input wire mc_family_t pkt_family,
    input wire logic pkt_needs_uc_route,
    input wire logic pkt_needs_mc_route,
    input wire logic lkp_hit,
    input wire logic [3:0] lkp_dev,
    input wire logic [5:0] lkp_port,
    input wire logic [11:0] lkp_index,
    input wire logic [3:0] hdr_src_dev,
    input wire fwd_kind_t hdr_kind,
    input wire logic [3:0] hdr_dst_dev,
    input wire logic [5:0] hdr_dst_port,
    input wire logic [11:0] hdr_index,
    output logic [11:0] pmt_index,
    input wire logic [55:0] group_mask,
    input wire logic [55:0] uc_miss_mask,
    input wire logic [55:0] bc_mask,
    input wire logic [55:0] l2_mc_miss_mask,
    input wire logic [55:0] ipv4_mc_miss_mask,
    input wire logic [55:0] ipv6_mc_miss_mask,
    input wire logic [15:0] link_fiber_10g,
    output logic [15:0] link_compact_framing,
    output logic [3:0] own_device_number,
    output logic [3:0] master_device_number,
    output logic res_valid,
    output logic res_drop,
    output logic [55:0] res_ports,
    output logic res_route,
    output logic [3:0] res_hdr_src_dev,
    output fwd_kind_t res_hdr_kind,
    output logic [3:0] res_hdr_dst_dev,
    output logic [5:0] res_hdr_dst_port,
    output logic [11:0] res_hdr_index
);
    // map a slot mask to the switch ports behind the slots
    function automatic logic [55:0] slot_to_ports(input logic [15:0] slots,
                                                  input logic [15:0][5:0] idx);
        logic [55:0] m;
        m = '0;
        for (int i = 0; i < NUM_SLOTS; i++)
        begin
            if (slots[i] && idx[i] <= PORT_IDX_MAX) // RQ2
                m[idx[i]] = 1'b1;
        end
        return m;
    endfunction

    // keep one member per link group; lowest slot wins
    function automatic logic [15:0] trunk_pick(input logic [15:0] sel,
                                               input logic [7:0][15:0] grp);
        logic [15:0] s;
        logic [15:0] hit;
        s = sel;
        for (int g = 0; g < NUM_TRUNKS; g++)
        begin
            hit = s & grp[g];
            if (hit != 16'h0000)
                s = (s & ~grp[g]) | (hit & (~hit + 16'h0001));
        end
        return s;
    endfunction

    logic [8:0] global_reg;
    logic [15:0] slot_en_reg;
    logic [15:0] block_reg;
    logic [15:0] drops_reg;
    logic [15:0][5:0] slot_port_reg;
    logic [7:0][15:0] trunk_reg;
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;
    logic rd_mem_reg;
    logic [15:0] devmask_bus;
    logic [15:0] devmask_fwd;
    logic [15:0] compact_reg;

    // register decode
    wire sel_global = reg_addr == ADDR_GLOBAL;
    wire sel_slot_en = reg_addr == ADDR_SLOT_EN;
    wire sel_block = reg_addr == ADDR_BLOCK;
    wire sel_drops = reg_addr == ADDR_DROPS;
    wire sel_slot = reg_addr[7:6] == REGION_SLOT;
    wire sel_dev = reg_addr[7:6] == REGION_DEVMASK;
    wire sel_trunk = reg_addr[7:5] == REGION_TRUNK;
    wire [3:0] reg_idx = reg_addr[5:2];
    wire discard_self = global_reg[DISCARD_BIT];

    assign own_device_number = global_reg[OWN_DEV_LSB +: 4]; // RQ1
    assign master_device_number = global_reg[MASTER_DEV_LSB +: 4]; // RQ1

    // global, slot enable and flood block registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            global_reg <= GLOBAL_RST;
            slot_en_reg <= SLOT_EN_RST;
            block_reg <= BLOCK_RST;
        end
        else if (reg_wr)
        begin
            if (sel_global)
                global_reg <= reg_wdata[8:0]; // RQ1
            if (sel_slot_en)
                slot_en_reg <= reg_wdata[15:0];
            if (sel_block)
                block_reg <= reg_wdata[15:0]; // RQ9
        end
    end

    // per-slot port index registers
    for (genvar s = 0; s < NUM_SLOTS; s++)
    begin : g_slot
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
                slot_port_reg[s] <= SLOT_PORT_RST;
            else if (reg_wr && sel_slot && reg_idx == 4'(s))
                slot_port_reg[s] <= reg_wdata[5:0]; // RQ2
        end
    end

    // link group member registers
    for (genvar t = 0; t < NUM_TRUNKS; t++)
    begin : g_trunk
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
                trunk_reg[t] <= TRUNK_RST;
            else if (reg_wr && sel_trunk && reg_addr[4:2] == 3'(t))
                trunk_reg[t] <= reg_wdata[15:0]; // RQ6
        end
    end

    // read data mux; unmapped addresses read zero
    always_comb
    begin
        rd_data_next = 32'h0000_0000;
        if (reg_rd)
        begin
            if (sel_global)
                rd_data_next = {23'h0, global_reg};
            else if (sel_slot_en)
                rd_data_next = {16'h0, slot_en_reg};
            else if (sel_block)
                rd_data_next = {16'h0, block_reg};
            else if (sel_drops)
                rd_data_next = {16'h0, drops_reg};
            else if (sel_slot)
                rd_data_next = {26'h0, slot_port_reg[reg_idx]};
            else if (sel_trunk)
                rd_data_next = {16'h0, trunk_reg[reg_addr[4:2]]};
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_data_reg <= 32'h0000_0000;
            rd_mem_reg <= 1'b0;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
            rd_mem_reg <= reg_rd && sel_dev;
        end
    end

    assign reg_rdata = rd_mem_reg ? {16'h0, devmask_bus} : rd_data_reg;

    // stage a: classify and pick the local flood mask
    fwd_kind_t a_kind_next;
    logic [55:0] a_flood_next;
    wire [3:0] a_dev_next = pkt_from_link ? hdr_dst_dev : lkp_dev; // RQ10 RQ11
    wire [5:0] a_port_next = pkt_from_link ? hdr_dst_port : lkp_port; // RQ10 RQ11
    wire a_drop_next = pkt_from_link && discard_self
                       && hdr_src_dev == own_device_number; // RQ8
    wire a_route_next = pkt_needs_mc_route
                        || (pkt_needs_uc_route && !pkt_from_link); // RQ17 RQ18

    assign pmt_index = pkt_from_link ? hdr_index : lkp_index; // RQ14

    always_comb
    begin
        if (pkt_from_link)
            a_kind_next = hdr_kind; // RQ11 RQ13
        else if (pkt_is_bc)
            a_kind_next = FWD_BCAST;
        else if (pkt_is_mc)
            a_kind_next = lkp_hit ? FWD_KNOWN_MC : FWD_UNKNOWN_MC;
        else
            a_kind_next = lkp_hit ? FWD_KNOWN_UC : FWD_UNKNOWN_UC; // RQ12
        case (a_kind_next)
            FWD_UNKNOWN_UC: a_flood_next = uc_miss_mask; // RQ12 RQ13
            FWD_KNOWN_MC: a_flood_next = group_mask; // RQ14
            FWD_UNKNOWN_MC:
                a_flood_next = pkt_family == FAM_IPV4 ? ipv4_mc_miss_mask
                             : pkt_family == FAM_IPV6 ? ipv6_mc_miss_mask
                             : l2_mc_miss_mask; // RQ15
            FWD_BCAST: a_flood_next = bc_mask; // RQ16
            default: a_flood_next = '0;
        endcase
    end

    logic a_valid;
    logic a_drop;
    logic a_route;
    fwd_kind_t a_kind;
    logic [55:0] a_flood;
    logic [3:0] a_dev;
    logic [5:0] a_port;
    logic [11:0] a_index;
    logic [3:0] a_src;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            a_valid <= 1'b0;
            a_drop <= 1'b0;
            a_route <= 1'b0;
            a_kind <= FWD_KNOWN_UC;
            a_flood <= '0;
            a_dev <= 4'h0;
            a_port <= 6'h00;
            a_index <= 12'h000;
            a_src <= 4'h0;
        end
        else
        begin
            a_valid <= pkt_valid;
            a_drop <= pkt_valid && a_drop_next;
            a_route <= a_route_next;
            a_kind <= a_kind_next;
            a_flood <= a_flood_next;
            a_dev <= a_dev_next;
            a_port <= a_port_next;
            a_index <= pmt_index;
            a_src <= pkt_from_link ? hdr_src_dev : own_device_number; // RQ20
        end
    end

    // dropped packet count shows the loop guard at work
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            drops_reg <= 16'h0000;
        else if (pkt_valid && a_drop_next)
            drops_reg <= drops_reg + 16'h0001; // RQ8
    end

    dev_link_mask_mem u_devmask (
        .clk(clk),
        .rstn(rstn),
        .wr_en(reg_wr && sel_dev),
        .wr_addr(reg_idx),
        .wr_data(reg_wdata[15:0]),
        .a_addr(reg_idx),
        .a_data(devmask_bus),
        .b_addr(a_dev_next),
        .b_data(devmask_fwd)
    );

    // stage b: turn slots into ports and build the answer
    wire remote_uc = a_kind == FWD_KNOWN_UC && a_dev != own_device_number; // RQ10
    wire [15:0] remote_slots = trunk_pick(devmask_fwd & slot_en_reg, trunk_reg); // RQ5 RQ6
    wire [55:0] remote_ports = slot_to_ports(remote_slots, slot_port_reg); // RQ5
    wire [55:0] blocked_ports = slot_to_ports(block_reg & slot_en_reg, slot_port_reg);
    wire [55:0] local_port = a_port <= PORT_IDX_MAX ? 56'h1 << a_port : '0;
    logic [55:0] b_ports_next;

    always_comb
    begin
        if (a_drop)
            b_ports_next = '0; // RQ8
        else if (remote_uc)
            b_ports_next = remote_ports; // RQ5 RQ10
        else if (a_kind == FWD_KNOWN_UC)
            b_ports_next = local_port; // RQ10 RQ11
        else
            b_ports_next = a_flood & ~blocked_ports; // RQ9
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            res_valid <= 1'b0;
            res_drop <= 1'b0;
            res_ports <= '0;
            res_route <= 1'b0;
            res_hdr_src_dev <= 4'h0;
            res_hdr_kind <= FWD_KNOWN_UC;
            res_hdr_dst_dev <= 4'h0;
            res_hdr_dst_port <= 6'h00;
            res_hdr_index <= 12'h000;
        end
        else
        begin
            res_valid <= a_valid;
            res_drop <= a_drop;
            res_ports <= b_ports_next;
            res_route <= a_valid && !a_drop && a_route; // RQ17 RQ18
            res_hdr_src_dev <= a_src; // RQ20
            res_hdr_kind <= a_kind; // RQ20
            res_hdr_dst_dev <= a_dev;
            res_hdr_dst_port <= a_port;
            res_hdr_index <= a_index; // RQ14
        end
    end

    // framing choice per enabled slot
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            compact_reg <= 16'h0000;
        else
            compact_reg <= slot_en_reg & link_fiber_10g; // RQ3 RQ4
    end

    assign link_compact_framing = compact_reg;

    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence pkt_in_s;
        pkt_valid && !pkt_from_link;
    endsequence

    sequence answer_s;
        ##2 res_valid && res_hdr_src_dev == own_device_number;
    endsequence

    own_dev_field_a: assert property (reg_wr && sel_global |=> // RQ1
        own_device_number == $past(reg_wdata[7:4]) && discard_self == $past(reg_wdata[8]))
        else $error("own device field not taken");
    remote_slots_a: assert property (res_valid && !res_drop // RQ5
        && res_hdr_kind == FWD_KNOWN_UC && res_hdr_dst_dev != own_device_number
        |-> (res_ports & ~slot_to_ports(slot_en_reg, slot_port_reg)) == 56'h0)
        else $error("remote unicast left on a non-link port");
    compact_frame_a: assert property ((link_compact_framing // RQ3
        & ~$past(link_fiber_10g)) == 16'h0000)
        else $error("compact framing on a non 10G fiber link"); // RQ4
    self_drop_a: assert property (pkt_valid && pkt_from_link && discard_self
        && hdr_src_dev == own_device_number && !reg_wr // RQ8
        |-> ##2 res_valid && res_drop && res_ports == 56'h0)
        else $error("self-origin packet not dropped");
    keep_foreign_a: assert property (pkt_valid && !discard_self && !reg_wr // RQ8
        |-> ##2 !res_drop)
        else $error("packet dropped while discard is off");
    block_mask_a: assert property (res_valid && res_hdr_kind != FWD_KNOWN_UC // RQ9
        && $stable(block_reg) && $stable(slot_en_reg)
        |-> (res_ports & blocked_ports) == 56'h0)
        else $error("non-unicast sent on a blocked link");
    route_once_a: assert property (pkt_valid && pkt_from_link // RQ17
        && !pkt_needs_mc_route |-> ##2 !res_route)
        else $error("unicast routed again by a neighbour");
    mc_route_a: assert property (pkt_valid && pkt_needs_mc_route // RQ18
        && !(pkt_from_link && discard_self) |-> ##2 res_route)
        else $error("multicast not routed here");
    header_src_a: assert property (pkt_in_s and !reg_wr |-> answer_s) // RQ20
        else $error("first device header lacks own number");
endmodule

/* File: stack_fwd_pkg.sv */
// Purpose: shared constants and types of the stacking forwarder
// Assumes: one 125 MHz clock domain, 32-bit register port, byte addresses
// Notes: all offsets are byte addresses of aligned words
package stack_fwd_pkg;
    // sizes of the stack
    localparam int NUM_DEVS = 16;
    localparam int NUM_SLOTS = 16;
    localparam int NUM_TRUNKS = 8;
    localparam int NUM_PORTS = 56;
    localparam logic [5:0] PORT_IDX_MAX = 6'h37;
    // register offsets
    localparam logic [7:0] ADDR_GLOBAL = 8'h00;
    localparam logic [7:0] ADDR_SLOT_EN = 8'h04;
    localparam logic [7:0] ADDR_BLOCK = 8'h08;
    localparam logic [7:0] ADDR_DROPS = 8'h0c;
    // register arrays by upper address bits
    localparam logic [1:0] REGION_SLOT = 2'h1;
    localparam logic [1:0] REGION_DEVMASK = 2'h2;
    localparam logic [2:0] REGION_TRUNK = 3'h6;
    // global control fields
    localparam int OWN_DEV_LSB = 4;
    localparam int MASTER_DEV_LSB = 0;
    localparam int DISCARD_BIT = 8;
    // reset values
    localparam logic [8:0] GLOBAL_RST = 9'h000;
    localparam logic [15:0] SLOT_EN_RST = 16'h0000;
    localparam logic [15:0] BLOCK_RST = 16'h0000;
    localparam logic [5:0] SLOT_PORT_RST = 6'h3f;
    localparam logic [15:0] TRUNK_RST = 16'h0000;
    // forwarding kind carried in the stacking header
    typedef enum logic [2:0] {
        FWD_KNOWN_UC,
        FWD_UNKNOWN_UC,
        FWD_KNOWN_MC,
        FWD_UNKNOWN_MC,
        FWD_BCAST
    } fwd_kind_t;
    // multicast family for miss flooding
    typedef enum logic [1:0] {
        FAM_L2,
        FAM_IPV4,
        FAM_IPV6
    } mc_family_t;
endpackage

/* File: dev_link_mask_mem.sv */
// Purpose: sixteen per-destination-device link masks
// Assumes: one write port, two read ports, read data one cycle later
// Notes: contents are not reset; read registers are
module dev_link_mask_mem
    import stack_fwd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [3:0] a_addr,
    output logic [15:0] a_data,
    input wire logic [3:0] b_addr,
    output logic [15:0] b_data
);
    logic [15:0] mem [NUM_DEVS];

    // storage write
    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    // registered reads for bus and forwarding path
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            a_data <= 16'h0000;
            b_data <= 16'h0000;
        end
        else
        begin
            a_data <= mem[a_addr];
            b_data <= mem[b_addr];
        end
    end
endmodule

/* File: stack_neighbor_model.sv */
// Purpose: neighbouring stack member that delivers a received stacking header
// Assumes: the forwarder reads the header only in the pkt_valid cycle
// Notes: outside a delivery the header lines show the inverse of the last value
module stack_neighbor_model
    import stack_fwd_pkg::*;
(
    input wire logic clk,
    input wire logic send,
    input wire logic [3:0] src_dev,
    input wire fwd_kind_t kind,
    input wire logic [3:0] dst_dev,
    input wire logic [5:0] dst_port,
    input wire logic [11:0] index,
    output logic from_link,
    output logic [3:0] hdr_src_dev,
    output fwd_kind_t hdr_kind,
    output logic [3:0] hdr_dst_dev,
    output logic [5:0] hdr_dst_port,
    output logic [11:0] hdr_index
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [28:0] last_reg = 29'h0;
    logic [28:0] now_hdr;
    logic [28:0] out_hdr;
    // header carries origin device, forwarding kind and destination
    assign now_hdr = {src_dev, kind, dst_dev, dst_port, index};
    // remember what went out so released lines move away from it
    always @(posedge clk)
    begin
        if (send)
        begin
            last_reg <= now_hdr;
        end
    end
    // lines are only meaningful while a packet is delivered
    assign from_link = send;
    assign out_hdr = send ? now_hdr : ~last_reg;
    assign hdr_src_dev = out_hdr[28:25];
    assign hdr_kind = fwd_kind_t'(out_hdr[24:22]);
    assign hdr_dst_dev = out_hdr[21:18];
    assign hdr_dst_port = out_hdr[17:12];
    assign hdr_index = out_hdr[11:0];
endmodule

/* File: switch_stacking_forwarder_tb.sv */
// Purpose: self-checking bench of the stacking forwarder
// Assumes: read data one cycle after the strobe, answer two cycles after pkt_valid
// Notes: the neighbour model supplies every header seen on a stacking link
module switch_stacking_forwarder_tb
    import stack_fwd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [55:0] ALL = 56'hff_ffff_ffff_ffff;
    localparam logic [55:0] P52 = 56'h1 << 52;
    localparam logic [55:0] P53 = 56'h1 << 53;
    localparam logic [11:0] IDX = 12'h064;
    logic clk, rstn, reg_wr, reg_rd, pkt_valid, pkt_is_mc, pkt_is_bc, lkp_hit, send;
    logic uc_route, mc_route, from_link, res_valid, res_drop, res_route;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    mc_family_t pkt_family;
    fwd_kind_t p_kind, h_kind, res_kind;
    logic [3:0] lkp_dev, p_src, p_dst, h_src, h_dst, own_dev, master_dev, res_src, res_dst;
    logic [5:0] lkp_port, p_port, h_port, res_port;
    logic [11:0] lkp_index, p_idx, h_idx, pmt_index, res_idx;
    logic [55:0] grp_mask, uc_mask, bc_mask, l2_mask, v4_mask, v6_mask, res_ports;
    logic [15:0] fiber, compact;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] rst_addr [7] = '{ADDR_GLOBAL, ADDR_SLOT_EN, ADDR_BLOCK, ADDR_DROPS, 8'h40,
                                 8'hc0, 8'h10};
    logic [31:0] rst_val [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3f, 32'h0, 32'h0};

    switch_stacking_forwarder u_switch_stacking_forwarder (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
        .pkt_from_link(from_link), .pkt_is_mc(pkt_is_mc), .pkt_is_bc(pkt_is_bc),
        .pkt_family(pkt_family), .pkt_needs_uc_route(uc_route),
        .pkt_needs_mc_route(mc_route), .lkp_hit(lkp_hit), .lkp_dev(lkp_dev),
        .lkp_port(lkp_port), .lkp_index(lkp_index), .hdr_src_dev(h_src), .hdr_kind(h_kind),
        .hdr_dst_dev(h_dst), .hdr_dst_port(h_port), .hdr_index(h_idx),
        .pmt_index(pmt_index), .group_mask(grp_mask), .uc_miss_mask(uc_mask),
        .bc_mask(bc_mask), .l2_mc_miss_mask(l2_mask), .ipv4_mc_miss_mask(v4_mask),
        .ipv6_mc_miss_mask(v6_mask), .link_fiber_10g(fiber), .link_compact_framing(compact),
        .own_device_number(own_dev), .master_device_number(master_dev),
        .res_valid(res_valid), .res_drop(res_drop), .res_ports(res_ports),
        .res_route(res_route), .res_hdr_src_dev(res_src), .res_hdr_kind(res_kind),
        .res_hdr_dst_dev(res_dst), .res_hdr_dst_port(res_port), .res_hdr_index(res_idx)
    );

    stack_neighbor_model u_stack_neighbor_model (
        .clk(clk), .send(send), .src_dev(p_src), .kind(p_kind), .dst_dev(p_dst),
        .dst_port(p_port), .index(p_idx), .from_link(from_link), .hdr_src_dev(h_src),
        .hdr_kind(h_kind), .hdr_dst_dev(h_dst), .hdr_dst_port(h_port), .hdr_index(h_idx)
    );

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard well above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [55:0] exp, input logic [55:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
    endtask

    // one descriptor; lookup fields disagree with the header on link packets
    task automatic pkt(input logic link, bc, mc, hit, input mc_family_t fam,
                       input fwd_kind_t kind, input logic [3:0] src, dev,
                       input logic [5:0] port, input logic ucr, mcr);
        @(posedge clk);
        pkt_valid <= 1'b1;
        send <= link;
        pkt_is_bc <= bc;
        pkt_is_mc <= mc;
        lkp_hit <= hit;
        pkt_family <= fam;
        uc_route <= ucr;
        mc_route <= mcr;
        p_kind <= kind;
        {p_src, p_dst, p_port, p_idx} <= {src, dev, port, IDX};
        lkp_dev <= link ? ~dev : dev;
        lkp_port <= link ? ~port : port;
        lkp_index <= link ? ~IDX : IDX;
        #1;
        chk("pmt_index", {44'h0, IDX}, {44'h0, pmt_index});
        @(posedge clk);
        pkt_valid <= 1'b0;
        send <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic chk_res(input logic [55:0] ports, input logic drop, route,
                           input logic [3:0] src);
        chk("res_valid", 56'h1, {55'h0, res_valid});
        chk("res_ports", ports, res_ports);
        chk("res_drop", {55'h0, drop}, {55'h0, res_drop});
        chk("res_route", {55'h0, route}, {55'h0, res_route});
        chk("res_hdr_src_dev", {52'h0, src}, {52'h0, res_src});
        // header kind and destination follow the descriptor that was sent
        chk("res_hdr_kind", {53'h0, p_kind}, {53'h0, res_kind});
        chk("res_hdr_dst", {46'h0, p_dst, p_port}, {46'h0, res_dst, res_port});
        chk("res_hdr_index", {44'h0, IDX}, {44'h0, res_idx});
    endtask

    // main sequence
    initial
    begin
        rstn = 1'b0;
        {reg_wr, reg_rd, pkt_valid, pkt_is_mc, pkt_is_bc, lkp_hit, send} = 7'h00;
        {uc_route, mc_route, reg_addr, reg_wdata} = 42'h0;
        pkt_family = FAM_L2;
        p_kind = FWD_KNOWN_UC;
        {lkp_dev, p_src, p_dst, lkp_port, p_port, lkp_index, p_idx} = 48'h0;
        fiber = 16'h000d;
        uc_mask = ALL; // stacking links included in the miss mask
        bc_mask = P53 | P52 | 56'hff;
        grp_mask = P53 | P52 | 56'h100;
        l2_mask = P53 | 56'h1;
        v4_mask = P53 | 56'h2;
        v6_mask = P53 | 56'h4;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        foreach (rst_addr[i]) reg_check(rst_addr[i], rst_val[i]);
        reg_write(ADDR_GLOBAL, 32'h135);
        reg_write(8'h40, 32'h34);
        reg_write(8'h44, 32'h35);
        reg_write(8'h48, 32'h3c);
        reg_write(ADDR_SLOT_EN, 32'h7);
        reg_write(8'hc0, 32'h3);
        reg_write(8'h98, 32'h7);
        reg_write(ADDR_BLOCK, 32'h2);
        reg_write(ADDR_DROPS, 32'hffff);
        reg_check(ADDR_GLOBAL, 32'h135);
        reg_check(8'h98, 32'h7);
        reg_check(ADDR_DROPS, 32'h0);
        chk("own_device_number", 56'h3, {52'h0, own_dev});
        chk("master_device_number", 56'h5, {52'h0, master_dev});
        chk("link_compact_framing", 56'h5, {40'h0, compact});
        pkt(0, 0, 0, 1, FAM_L2, FWD_KNOWN_UC, 4'h0, 4'h6, 6'h00, 1, 0);
        chk_res(P52, 0, 1, 4'h3);
        pkt(0, 0, 0, 1, FAM_L2, FWD_KNOWN_UC, 4'h0, 4'h3, 6'h0a, 0, 0);
        chk_res(56'h400, 0, 0, 4'h3);
        pkt(0, 0, 0, 1, FAM_L2, FWD_KNOWN_UC, 4'h0, 4'h3, 6'h38, 0, 0);
        chk_res(56'h0, 0, 0, 4'h3);
        pkt(1, 0, 0, 0, FAM_L2, FWD_KNOWN_UC, 4'h9, 4'h3, 6'h07, 1, 0);
        chk_res(56'h80, 0, 0, 4'h9);
        pkt(0, 0, 0, 0, FAM_L2, FWD_UNKNOWN_UC, 4'h9, 4'h0, 6'h00, 0, 0);
        chk_res(ALL & ~P53, 0, 0, 4'h3);
        pkt(1, 0, 0, 0, FAM_L2, FWD_UNKNOWN_UC, 4'h9, 4'h0, 6'h00, 0, 0);
        chk_res(ALL & ~P53, 0, 0, 4'h9);
        pkt(0, 1, 1, 1, FAM_L2, FWD_BCAST, 4'h9, 4'h0, 6'h00, 0, 0);
        chk_res(bc_mask & ~P53, 0, 0, 4'h3);
        pkt(1, 0, 0, 0, FAM_L2, FWD_BCAST, 4'h9, 4'h0, 6'h00, 0, 0);
        chk_res(bc_mask & ~P53, 0, 0, 4'h9);
        pkt(0, 0, 1, 1, FAM_L2, FWD_KNOWN_MC, 4'h9, 4'h0, 6'h00, 0, 1);
        chk_res(grp_mask & ~P53, 0, 1, 4'h3);
        pkt(1, 0, 0, 0, FAM_L2, FWD_KNOWN_MC, 4'h9, 4'h0, 6'h00, 1, 1);
        chk_res(grp_mask & ~P53, 0, 1, 4'h9);
        for (int f = 0; f < 6; f++)
        begin
            pkt(f[0], 0, 1, 0, mc_family_t'(f / 2), FWD_UNKNOWN_MC, 4'h9, 4'h0, 6'h00, 0, 0);
            chk_res(56'h1 << (f / 2), 0, 0, f[0] ? 4'h9 : 4'h3);
        end
        pkt(1, 0, 0, 0, FAM_L2, FWD_KNOWN_UC, 4'h3, 4'h3, 6'h07, 0, 1);
        chk_res(56'h0, 1, 0, 4'h3);
        reg_write(ADDR_GLOBAL, 32'h035);
        pkt(1, 0, 0, 0, FAM_L2, FWD_KNOWN_UC, 4'h3, 4'h3, 6'h07, 0, 1);
        chk_res(56'h80, 0, 1, 4'h3);
        reg_check(ADDR_DROPS, 32'h1);
        test_done();
    end
endmodule
